// ### rtl/ocp_consts.vh
`ifndef OCP_CONSTS_VH
`define OCP_CONSTS_VH
// Operation
// RULE1: Electrical trips latch and stop the engine through a controlled sequence
// RULE2: Trip start first drops the load-connect output
// RULE3: After unloading, run the cooldown timer, then stop the engine
// RULE4: Latched trip clears on operator clear only once its cause is gone
// RULE5: High current warns first, escalates to shutdown or trip if persistent
// RULE6: Total kW above the overload limit raises a trip
// RULE7: Earth current above its limit raises a trip
// RULE8: Voltage below loading level at safety expiry shuts down
// RULE9: Frequency below loading level at safety expiry shuts down
// RULE10: Bypass shows alarms without stopping; each bypassed event is logged
// RULE11: Grid sensing overload flags low capacity, flashes lamp, full output
// RULE12: Under frequency, under voltage and underspeed raise alarms
// RULE13: Fuel used above its limit raises an alarm
// RULE14: Instant warning asserts once current reaches the trip level
// RULE15: Instant warning self-clears below trip level unless warnings latch
// RULE16: Inverse-time tracking starts once current passes the trip level
// RULE17: Inverse-time alarm fires past the curve, doing the chosen action
// RULE18: High current shutdown latches; clears after fault gone and clear
// RULE19: Trip time is multiplier over squared excess ratio
// RULE20: Curve current is the largest of the three line currents
// RULE21: Multiplier equals trip time at twice the trip current
// RULE22: Heat decays below trip level so repeats trip sooner
// RULE23: Thermal accumulator rises above trip level, decays below, trips full

`define OCP_CTRL       8'h00
`define OCP_TRIP_I     8'h04
`define OCP_TMULT      8'h08
`define OCP_KW_LIM     8'h0C
`define OCP_EARTH_LIM  8'h10
`define OCP_LOAD_V     8'h14
`define OCP_LOAD_F     8'h18
`define OCP_UV_LIM     8'h1C
`define OCP_UF_LIM     8'h20
`define OCP_US_LIM     8'h24
`define OCP_FUEL_LIM   8'h28
`define OCP_GRID_SET   8'h2C
`define OCP_COOL_T     8'h30
`define OCP_SAFE_T     8'h34
`define OCP_STATUS     8'h38
`define OCP_BYP_LOG    8'h3C
`define OCP_HEAT       8'h40

`define OCP_C_IMM      0
`define OCP_C_IDMT     1
`define OCP_C_ACT      2
`define OCP_C_LATCH    3
`define OCP_C_BYPASS   4
`define OCP_C_GRID     5
`define OCP_C_ACK      6

`define OCP_CTRL_RST   8'h07
`define OCP_TRIP_RST   16'h01F4
`define OCP_TMULT_RST  16'h0024
`define OCP_HI_RST     16'hFFFF
`define OCP_LO_RST     16'h0000
`define OCP_TIME_RST   16'h2710

`define OCP_LATCH_MSK  12'h07E
`define OCP_WARN_MSK   12'hF81
`define OCP_SD_MSK     12'h062
`define OCP_TRIP_MSK   12'h01C

`define OCP_CLK_NS     10
`define OCP_TICK_US    1000
`define OCP_TICK_CYC   (`OCP_TICK_US * 1000 / `OCP_CLK_NS)
`define OCP_TICK_PER_S (1000000 / `OCP_TICK_US)
`define OCP_FLASH_MS   500
`define OCP_FLASH_TK   (`OCP_FLASH_MS * 1000 / `OCP_TICK_US)
`define OCP_COOL_SHIFT 12
`endif

// ### rtl/ocp_therm_acc.v
`timescale 1ns/1ps
`include "ocp_consts.vh"
module ocp_therm_acc (
  input  wire        clk,
  input  wire        nrst,
  input  wire        tick,
  input  wire        enable,
  input  wire [15:0] cur_max,
  input  wire [15:0] trip_lvl,
  input  wire [15:0] time_mult,
  output reg         trip_ff,
  output wire [31:0] heat
);
  localparam [63:0] TPS = `OCP_TICK_PER_S;
  reg  [63:0] acc_ff;
  reg  [63:0] nxt_acc;
  wire        over    = cur_max > trip_lvl;
  wire [15:0] excess  = cur_max - trip_lvl;
  wire [31:0] sq      = excess * excess;
  wire [31:0] trip_sq = trip_lvl * trip_lvl;
  // Full scale = trip^2 * mult * ticks per second, so the curve holds exactly
  wire [63:0] full    = {32'h0000_0000, trip_sq} * {48'h0000_0000_0000,
                        time_mult} * TPS; // [RULE19] [RULE21]
  wire [63:0] sum     = acc_ff + {32'h0000_0000, sq};

  always @* begin
    nxt_acc = acc_ff;
    if (!enable)
      nxt_acc = 64'h0000_0000_0000_0000;
    else if (tick && over)
      nxt_acc = (sum > full) ? full : sum; // [RULE16] [RULE23]
    else if (tick && acc_ff != 64'h0000_0000_0000_0000)
      // Exponential cooling; the extra 1 lets it reach zero
      nxt_acc = acc_ff - (acc_ff >> `OCP_COOL_SHIFT)
                - 64'h0000_0000_0000_0001; // [RULE22]
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff  <= 64'h0000_0000_0000_0000;
      trip_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      trip_ff <= enable && (acc_ff >= full); // [RULE17] [RULE23]
    end
  end

  assign heat = acc_ff[57:26];
endmodule

// ### rtl/ocp_trip_prot.v
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "ocp_consts.vh"
module ocp_trip_prot #(
  parameter TICK_CYC = `OCP_TICK_CYC
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [15:0] cur_l1,
  input  wire [15:0] cur_l2,
  input  wire [15:0] cur_l3,
  input  wire [15:0] kw_total,
  input  wire [15:0] earth_cur,
  input  wire [15:0] gen_volt,
  input  wire [15:0] gen_freq,
  input  wire [15:0] eng_speed,
  input  wire [15:0] fuel_used,
  input  wire [15:0] grid_level,
  input  wire        load_request,
  input  wire        engine_running_pin,
  input  wire        halt_clear_btn_n,
  output reg         load_connect_ff,
  output reg         engine_stop_ff,
  output reg         gen_full_output_ff,
  output reg         shared_alarm_lamp_ff,
  output reg         prot_disabled_ff
);
  localparam [3:0] ST_RUN    = 4'b0001;
  localparam [3:0] ST_UNLOAD = 4'b0010;
  localparam [3:0] ST_COOL   = 4'b0100;
  localparam [3:0] ST_HALT   = 4'b1000;
  localparam [16:0] TICK_LAST = TICK_CYC - 1;
  localparam [15:0] FLASH_LAST = `OCP_FLASH_TK - 1;

  reg  [7:0]  ctrl_ff;
  reg  [15:0] trip_i_ff;
  reg  [15:0] tmult_ff;
  reg  [15:0] kw_lim_ff;
  reg  [15:0] earth_lim_ff;
  reg  [15:0] load_v_ff;
  reg  [15:0] load_f_ff;
  reg  [15:0] uv_lim_ff;
  reg  [15:0] uf_lim_ff;
  reg  [15:0] us_lim_ff;
  reg  [15:0] fuel_lim_ff;
  reg  [15:0] grid_set_ff;
  reg  [15:0] cool_t_ff;
  reg  [15:0] safe_t_ff;
  reg  [15:0] byp_log_ff;
  reg  [11:0] alarm_ff;
  reg  [11:0] nxt_alarm;
  reg  [11:0] cause;
  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [15:0] cool_cnt_ff;
  reg  [15:0] nxt_cool_cnt;
  reg  [15:0] safe_cnt_ff;
  reg         safe_done_ff;
  reg  [16:0] tick_cnt_ff;
  reg  [15:0] flash_cnt_ff;
  reg         flash_ff;
  reg  [1:0]  pin_s1_ff;
  reg  [1:0]  pin_s2_ff;
  reg  [1:0]  pin_s3_ff;
  reg  [1:0]  pin_filt_ff;
  reg         btn_prev_ff;
  reg  [15:0] cur_max;
  wire        wr_en   = psel && penable && pwrite;
  wire        tick    = (tick_cnt_ff == TICK_LAST);
  wire        running = pin_filt_ff[0];
  wire        pressed = ~pin_filt_ff[1];
  wire        ack_wr  = wr_en && (paddr == `OCP_CTRL) && pwdata[`OCP_C_ACK];
  wire        clr     = ack_wr || (pressed && !btn_prev_ff);
  wire        bypass  = ctrl_ff[`OCP_C_BYPASS];
  wire        act_trip = ctrl_ff[`OCP_C_ACT];
  wire        latch_all = ctrl_ff[`OCP_C_LATCH];
  wire        therm_trip;
  wire [31:0] heat;
  wire        safe_exp = running && !safe_done_ff && (safe_cnt_ff >= safe_t_ff);
  wire [11:0] lmask = `OCP_LATCH_MSK | (latch_all ? `OCP_WARN_MSK : 12'h000);
  wire        sd_on   = |(alarm_ff & `OCP_SD_MSK) && !bypass;
  wire        trip_on = |(alarm_ff & `OCP_TRIP_MSK) && !bypass;
  wire        new_hard = |(cause & ~alarm_ff & (`OCP_SD_MSK | `OCP_TRIP_MSK));
  reg         addr_ok;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always @* begin
    cur_max = cur_l1; // [RULE20]
    if (cur_l2 > cur_max)
      cur_max = cur_l2;
    if (cur_l3 > cur_max)
      cur_max = cur_l3;
  end

  ocp_therm_acc u_therm (
    .clk       (clk),
    .nrst      (nrst),
    .tick      (tick),
    .enable    (ctrl_ff[`OCP_C_IDMT]),
    .cur_max   (cur_max),
    .trip_lvl  (trip_i_ff),
    .time_mult (tmult_ff),
    .trip_ff   (therm_trip),
    .heat      (heat)
  );

  always @* begin
    cause     = 12'h000;
    cause[0]  = ctrl_ff[`OCP_C_IMM] && (cur_max >= trip_i_ff); // [RULE14] [RULE5]
    cause[1]  = therm_trip && !act_trip; // [RULE17] [RULE18] [RULE5]
    cause[2]  = therm_trip && act_trip;  // [RULE17] [RULE5]
    cause[3]  = kw_total > kw_lim_ff;    // [RULE6]
    cause[4]  = earth_cur > earth_lim_ff; // [RULE7]
    cause[5]  = safe_exp && (gen_volt <= load_v_ff); // [RULE8]
    cause[6]  = safe_exp && (gen_freq <= load_f_ff); // [RULE9]
    cause[7]  = safe_done_ff && (gen_freq < uf_lim_ff);  // [RULE12]
    cause[8]  = safe_done_ff && (gen_volt < uv_lim_ff);  // [RULE12]
    cause[9]  = safe_done_ff && (eng_speed < us_lim_ff); // [RULE12]
    cause[10] = fuel_used > fuel_lim_ff; // [RULE13]
    cause[11] = ctrl_ff[`OCP_C_GRID] && (grid_level > grid_set_ff); // [RULE11]
    // A live cause always wins over a clear in the same cycle
    nxt_alarm = cause | (alarm_ff & lmask & ~{12{clr}}); // [RULE1] [RULE4] [RULE15] [RULE18]
  end

  always @* begin
    nxt_state    = state_ff;
    nxt_cool_cnt = cool_cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (sd_on)
          nxt_state = ST_HALT;
        else if (trip_on)
          nxt_state = ST_UNLOAD; // [RULE1] [RULE2]
      end
      ST_UNLOAD: begin
        nxt_cool_cnt = 16'h0000;
        nxt_state    = sd_on ? ST_HALT : ST_COOL; // [RULE3]
      end
      ST_COOL: begin
        if (tick)
          nxt_cool_cnt = cool_cnt_ff + 16'h0001;
        if (sd_on || cool_cnt_ff >= cool_t_ff)
          nxt_state = ST_HALT; // [RULE3]
      end
      ST_HALT: begin
        if (!sd_on && !trip_on)
          nxt_state = ST_RUN; // [RULE4]
      end
      default: nxt_state = ST_HALT;
    endcase
  end

  always @* begin
    addr_ok = 1'b1;
    prdata  = 32'h0000_0000;
    case (paddr)
      `OCP_CTRL:      prdata = {24'h00_0000, 1'b0, ctrl_ff[6:0] & 7'h3F};
      `OCP_TRIP_I:    prdata = {16'h0000, trip_i_ff};
      `OCP_TMULT:     prdata = {16'h0000, tmult_ff};
      `OCP_KW_LIM:    prdata = {16'h0000, kw_lim_ff};
      `OCP_EARTH_LIM: prdata = {16'h0000, earth_lim_ff};
      `OCP_LOAD_V:    prdata = {16'h0000, load_v_ff};
      `OCP_LOAD_F:    prdata = {16'h0000, load_f_ff};
      `OCP_UV_LIM:    prdata = {16'h0000, uv_lim_ff};
      `OCP_UF_LIM:    prdata = {16'h0000, uf_lim_ff};
      `OCP_US_LIM:    prdata = {16'h0000, us_lim_ff};
      `OCP_FUEL_LIM:  prdata = {16'h0000, fuel_lim_ff};
      `OCP_GRID_SET:  prdata = {16'h0000, grid_set_ff};
      `OCP_COOL_T:    prdata = {16'h0000, cool_t_ff};
      `OCP_SAFE_T:    prdata = {16'h0000, safe_t_ff};
      `OCP_STATUS:    prdata = {14'h0000, load_connect_ff, safe_done_ff,
                                state_ff, alarm_ff};
      `OCP_BYP_LOG:   prdata = {16'h0000, byp_log_ff};
      `OCP_HEAT:      prdata = heat;
      default:        addr_ok = 1'b0;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff      <= `OCP_CTRL_RST;
      trip_i_ff    <= `OCP_TRIP_RST;
      tmult_ff     <= `OCP_TMULT_RST;
      kw_lim_ff    <= `OCP_HI_RST;
      earth_lim_ff <= `OCP_HI_RST;
      load_v_ff    <= `OCP_LO_RST;
      load_f_ff    <= `OCP_LO_RST;
      uv_lim_ff    <= `OCP_LO_RST;
      uf_lim_ff    <= `OCP_LO_RST;
      us_lim_ff    <= `OCP_LO_RST;
      fuel_lim_ff  <= `OCP_HI_RST;
      grid_set_ff  <= `OCP_HI_RST;
      cool_t_ff    <= `OCP_TIME_RST;
      safe_t_ff    <= `OCP_TIME_RST;
    end else if (wr_en) begin
      case (paddr)
        `OCP_CTRL:      ctrl_ff      <= {2'b00, pwdata[5:0]};
        `OCP_TRIP_I:    trip_i_ff    <= pwdata[15:0];
        `OCP_TMULT:     tmult_ff     <= pwdata[15:0];
        `OCP_KW_LIM:    kw_lim_ff    <= pwdata[15:0];
        `OCP_EARTH_LIM: earth_lim_ff <= pwdata[15:0];
        `OCP_LOAD_V:    load_v_ff    <= pwdata[15:0];
        `OCP_LOAD_F:    load_f_ff    <= pwdata[15:0];
        `OCP_UV_LIM:    uv_lim_ff    <= pwdata[15:0];
        `OCP_UF_LIM:    uf_lim_ff    <= pwdata[15:0];
        `OCP_US_LIM:    us_lim_ff    <= pwdata[15:0];
        `OCP_FUEL_LIM:  fuel_lim_ff  <= pwdata[15:0];
        `OCP_GRID_SET:  grid_set_ff  <= pwdata[15:0];
        `OCP_COOL_T:    cool_t_ff    <= pwdata[15:0];
        `OCP_SAFE_T:    safe_t_ff    <= pwdata[15:0];
        default:        ctrl_ff      <= ctrl_ff;
      endcase
    end
  end

  // Pins pass three flops; a change counts once the last two agree
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff   <= 2'b10;
      pin_s2_ff   <= 2'b10;
      pin_s3_ff   <= 2'b10;
      pin_filt_ff <= 2'b10;
      btn_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff   <= {halt_clear_btn_n, engine_running_pin};
      pin_s2_ff   <= pin_s1_ff;
      pin_s3_ff   <= pin_s2_ff;
      pin_filt_ff <= (pin_s2_ff & pin_s3_ff) |
                     (pin_filt_ff & (pin_s2_ff ^ pin_s3_ff));
      btn_prev_ff <= pressed;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff  <= 17'h0_0000;
      flash_cnt_ff <= 16'h0000;
      flash_ff     <= 1'b0;
      safe_cnt_ff  <= 16'h0000;
      safe_done_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick ? 17'h0_0000 : tick_cnt_ff + 17'h0_0001;
      if (tick) begin
        flash_cnt_ff <= (flash_cnt_ff == FLASH_LAST) ? 16'h0000 :
                        flash_cnt_ff + 16'h0001;
        if (flash_cnt_ff == FLASH_LAST)
          flash_ff <= ~flash_ff;
      end
      // Safety window restarts each time the engine starts
      if (!running) begin
        safe_cnt_ff  <= 16'h0000;
        safe_done_ff <= 1'b0;
      end else if (safe_exp) begin
        safe_done_ff <= 1'b1;
      end else if (tick && !safe_done_ff) begin
        safe_cnt_ff <= safe_cnt_ff + 16'h0001;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_ff             <= 12'h000;
      state_ff             <= ST_RUN;
      cool_cnt_ff          <= 16'h0000;
      byp_log_ff           <= 16'h0000;
      load_connect_ff      <= 1'b0;
      engine_stop_ff       <= 1'b0;
      gen_full_output_ff   <= 1'b0;
      shared_alarm_lamp_ff <= 1'b0;
      prot_disabled_ff     <= 1'b0;
    end else begin
      alarm_ff    <= nxt_alarm;
      state_ff    <= nxt_state;
      cool_cnt_ff <= nxt_cool_cnt;
      if (bypass && new_hard && byp_log_ff != 16'hFFFF)
        byp_log_ff <= byp_log_ff + 16'h0001; // [RULE10]
      // Load drops in the same edge the trip sequence leaves run
      load_connect_ff <= load_request && (nxt_state == ST_RUN) &&
                         (state_ff == ST_RUN); // [RULE2]
      engine_stop_ff  <= (nxt_state == ST_HALT); // [RULE1] [RULE18]
      gen_full_output_ff <= cause[11]; // [RULE11]
      // Low capacity flashes, even with other alarms; any other alarm alone lights steadily
      shared_alarm_lamp_ff <= alarm_ff[11] ? flash_ff :
                              |alarm_ff; // [RULE11]
      prot_disabled_ff <= bypass; // [RULE10]
    end
  end
endmodule

// ### verification/ocp_genset_model.sv
`timescale 1ns/1ps
module ocp_genset_model (
  input  logic clk,
  input  logic nrst,
  input  logic engine_stop,
  input  logic press,
  output logic engine_running_pin,
  output logic halt_clear_btn_n
);
  logic       run_ff;
  logic [3:0] hold_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 1'b0;
      hold_ff <= 4'h0;
    end else begin
      run_ff <= !engine_stop;
      // Held past the pin filter so one press gives one clear
      if (press) hold_ff <= 4'h8;
      else if (hold_ff != 4'h0) hold_ff <= hold_ff - 4'h1;
    end
  end
  assign engine_running_pin = run_ff;
  assign halt_clear_btn_n = (hold_ff == 4'h0);
endmodule

// ### verification/ocp_trip_prot_bench.sv
`timescale 1ns/1ps
`include "ocp_consts.vh"
module ocp_trip_prot_bench;
  logic        clk = 0, nrst = 0, press = 0, load_request = 1;
  logic        psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, q;
  wire  [31:0] prdata;
  wire         pready, pslverr, engine_running_pin, halt_clear_btn_n;
  wire         load_connect_ff, engine_stop_ff, gen_full_output_ff;
  wire         shared_alarm_lamp_ff, prot_disabled_ff;
  logic [15:0] cur_l1 = 16'h0003, cur_l2 = 16'h0003, cur_l3 = 16'h0003;
  logic [15:0] kw_total = 0, earth_cur = 0, grid_level = 0;
  logic [15:0] gen_volt = 16'h00e6, gen_freq = 16'h0032;
  logic [15:0] eng_speed = 16'h05dc, fuel_used = 16'h0064;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  ocp_trip_prot #(.TICK_CYC(10)) DUT (.clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cur_l1, .cur_l2, .cur_l3,
    .kw_total, .earth_cur, .gen_volt, .gen_freq, .eng_speed, .fuel_used,
    .grid_level, .load_request, .engine_running_pin, .halt_clear_btn_n,
    .load_connect_ff, .engine_stop_ff, .gen_full_output_ff,
    .shared_alarm_lamp_ff, .prot_disabled_ff);
  ocp_genset_model u_gen (.clk, .nrst, .engine_stop(engine_stop_ff), .press,
    .engine_running_pin, .halt_clear_btn_n);
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_checks++;
    if (got !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat(input int b, input logic ex);
    apb(1'b0, `OCP_STATUS, 32'h0000_0000);
    chk("status bit", {31'h0, ex}, {31'h0, q[b]});
  endtask
  task automatic pins(input logic ld, input logic st);
    chk("load_connect_ff", {31'h0, ld}, {31'h0, load_connect_ff});
    chk("engine_stop_ff", {31'h0, st}, {31'h0, engine_stop_ff});
  endtask
  task automatic ticks(input int n);
    repeat (n * 10) @(posedge clk);
  endtask
  task automatic clear_all;
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic t_regs;
    logic [7:0]  ra [4] = '{`OCP_CTRL, `OCP_TRIP_I, `OCP_TMULT, `OCP_KW_LIM};
    logic [15:0] rv [4] = '{16'h0007, `OCP_TRIP_RST, `OCP_TMULT_RST,
                            `OCP_HI_RST};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk("reset value", {16'h0, rv[i]}, q);
    end
    apb(1'b0, 8'h44, 32'h0000_0000);
    chk("unmapped pslverr", 32'h1, {31'h0, e});
    apb(1'b1, `OCP_COOL_T, 32'h0000_0003);
    apb(1'b1, `OCP_SAFE_T, 32'h0000_0005);
    apb(1'b1, `OCP_TRIP_I, 32'h0000_0004);
    apb(1'b1, `OCP_TMULT, 32'h0000_0001);
    apb(1'b0, `OCP_COOL_T, 32'h0000_0000);
    chk("cool time", 32'h0000_0003, q);
    $display("test regs done");
  endtask
  task automatic t_warn;
    apb(1'b1, `OCP_CTRL, 32'h0000_0001);
    cur_l1 <= 16'h0004;
    ticks(1);
    stat(0, 1'b1);
    pins(1'b1, 1'b0);
    cur_l1 <= 16'h0003;
    ticks(1);
    stat(0, 1'b0);
    apb(1'b1, `OCP_CTRL, 32'h0000_0009);
    cur_l1 <= 16'h0004;
    ticks(1);
    cur_l1 <= 16'h0003;
    ticks(1);
    stat(0, 1'b1);
    apb(1'b1, `OCP_CTRL, 32'h0000_0049);
    stat(0, 1'b0);
    $display("test warn done");
  endtask
  task automatic t_kw;
    apb(1'b1, `OCP_CTRL, 32'h0000_0000);
    apb(1'b1, `OCP_KW_LIM, 32'h0000_0064);
    kw_total <= 16'h0065;
    repeat (4) @(posedge clk);
    pins(1'b0, 1'b0);
    stat(3, 1'b1);
    repeat (6) @(posedge clk);
    pins(1'b0, 1'b0);
    repeat (30) @(posedge clk);
    pins(1'b0, 1'b1);
    clear_all;
    pins(1'b0, 1'b1);
    kw_total <= 16'h0000;
    repeat (10) @(posedge clk);
    pins(1'b0, 1'b1);
    clear_all;
    stat(3, 1'b0);
    $display("test kw done");
  endtask
  task automatic t_bypass;
    ticks(8);
    apb(1'b1, `OCP_CTRL, 32'h0000_0010);
    apb(1'b1, `OCP_EARTH_LIM, 32'h0000_0032);
    earth_cur <= 16'h003c;
    ticks(3);
    stat(4, 1'b1);
    pins(1'b1, 1'b0);
    chk("prot_disabled_ff", 32'h1, {31'h0, prot_disabled_ff});
    apb(1'b0, `OCP_BYP_LOG, 32'h0000_0000);
    chk("bypass log", 32'h0000_0001, q);
    earth_cur <= 16'h0000;
    apb(1'b1, `OCP_CTRL, 32'h0000_0050);
    apb(1'b1, `OCP_CTRL, 32'h0000_0000);
    stat(4, 1'b0);
    $display("test bypass done");
  endtask
  task automatic t_idmt;
    apb(1'b1, `OCP_CTRL, 32'h0000_0007);
    // Twice the trip level on one line only; one second is 1000 ticks
    cur_l2 <= 16'h0008;
    ticks(1);
    stat(0, 1'b1);
    ticks(940);
    stat(2, 1'b0);
    ticks(100);
    stat(2, 1'b1);
    pins(1'b0, 1'b1);
    cur_l2 <= 16'h0003;
    for (int act = 1; act >= 0; act--) begin
      ticks(100);
      clear_all;
      apb(1'b1, `OCP_CTRL, act == 1 ? 32'h0000_0007 : 32'h0000_0003);
      cur_l2 <= 16'h0008;
      ticks(200);
      stat(act == 1 ? 2 : 1, 1'b1);
      pins(1'b0, 1'b1);
      cur_l2 <= 16'h0003;
    end
    ticks(100);
    clear_all;
    $display("test idmt done");
  endtask
  task automatic t_limits;
    logic [7:0]  la [6] = '{8'h14, 8'h18, 8'h20, 8'h1c, 8'h24, 8'h28};
    logic [15:0] lv [6] = '{16'h012c, 16'h003c, 16'h003c, 16'h012c,
                            16'h07d0, 16'h0032};
    // Loading limits only count at safety expiry, so set them before it
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, la[i], {16'h0, lv[i]});
      ticks(20);
      stat(i + 5, 1'b1);
      chk("engine_stop_ff", {31'h0, i < 2}, {31'h0, engine_stop_ff});
      apb(1'b1, la[i], i == 5 ? 32'h0000_ffff : 32'h0000_0000);
      apb(1'b1, `OCP_CTRL, 32'h0000_0040);
      stat(i + 5, 1'b0);
    end
    $display("test limits done");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_warn;
    t_kw;
    t_bypass;
    t_idmt;
    t_limits;
    close_out;
  end
endmodule

// ### verification/ocp_trip_prot_chk.sv
`timescale 1ns/1ps
module ocp_trip_prot_chk (
  input logic        clk,
  input logic        nrst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pslverr,
  input logic        halt_clear_btn_n,
  input logic        load_connect_ff,
  input logic        engine_stop_ff,
  input logic        gen_full_output_ff,
  input logic        shared_alarm_lamp_ff,
  input logic        prot_disabled_ff
);
  logic [3:0] age_ff;
  wire        acc = psel && penable;
  wire        ack = acc && pwrite && paddr == 8'h00 && pwdata[6];
  // Cycles since the last operator clear, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) age_ff <= 4'hf;
    else if (!halt_clear_btn_n || ack) age_ff <= 4'h0;
    else if (age_ff != 4'hf) age_ff <= age_ff + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_unmapped_err: assert property (acc && paddr > 8'h40 |->
    pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && paddr <= 8'h40 && paddr[1:0] == 2'b00
    |-> !pslverr && prdata[31:18] == 14'h0) else $error("mapped read bad");
  a_ack_reads_zero: assert property (acc && !pwrite && paddr == 8'h00
    |-> prdata[31:6] == 26'h0) else $error("control high bits set");
  a_stop_unloaded: assert property (
    engine_stop_ff |-> !load_connect_ff) else $error("stopped under load");
  a_stop_lamp: assert property (
    $rose(engine_stop_ff) && !gen_full_output_ff |-> ##[0:2]
    shared_alarm_lamp_ff) else $error("stop without alarm lamp");
  a_stop_cleared: assert property (
    $fell(engine_stop_ff) |-> age_ff < 4'd12) else $error("stop dropped");
  a_bypass_hold: assert property (
    prot_disabled_ff && $past(prot_disabled_ff) |-> !$rose(engine_stop_ff))
    else $error("bypass stopped engine");
  a_bypass_cfg: assert property (
    acc && pwrite && paddr == 8'h00 |-> ##2
    prot_disabled_ff == $past(pwdata[4], 2)) else $error("bypass flag");
  c_stop: cover property ($rose(engine_stop_ff));
  c_refused: cover property (acc && pslverr);
  c_bypass: cover property (prot_disabled_ff && shared_alarm_lamp_ff);
endmodule
bind ocp_trip_prot ocp_trip_prot_chk u_chk (.clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .halt_clear_btn_n,
  .load_connect_ff, .engine_stop_ff, .gen_full_output_ff,
  .shared_alarm_lamp_ff, .prot_disabled_ff);
